// ===== core/ssbs_consts.svh
// register offsets, field positions, reset values and timing counts of the supply sequencer
`ifndef SSBS_CONSTS_SVH
`define SSBS_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSBS_OFS_CTRL 8'h00
`define SSBS_OFS_STATUS 8'h04
`define SSBS_OFS_WIN_RELOAD 8'h08
`define SSBS_OFS_ARM_RELOAD 8'h0c
`define SSBS_OFS_STEP_COUNT 8'h10
`define SSBS_OFS_INT_STATUS 8'h14
`define SSBS_OFS_INT_MASK 8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSBS_CTRL_BURST_EN 0
`define SSBS_EV_BROWNIN 0
`define SSBS_EV_BROWNOUT 1
`define SSBS_EV_PROTECT 2
`define SSBS_EV_RESTART 3
`define SSBS_EV_BURST 4
`define SSBS_EV_HWRESET 5
`define SSBS_EV_W 6
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define SSBS_CTRL_RST 1'b1
`define SSBS_STEP_RST 8'h08
`define SSBS_CLK_NS 8
`define SSBS_WIN_NS 100000
`define SSBS_ARM_NS 1000000
`define SSBS_WIN_CYC (`SSBS_WIN_NS / `SSBS_CLK_NS)
`define SSBS_ARM_CYC (`SSBS_ARM_NS / `SSBS_CLK_NS)
`define SSBS_INIT_CYC 4'hf
`endif

// ===== core/ssbs_pkg.sv
// types of the supply sequencer
package ssbs_pkg;
  typedef enum logic [3:0] {
    S_CHARGE = 4'h0,
    S_INIT = 4'h1,
    S_BI_ACTIVE = 4'h2,
    S_BI_SLEEP = 4'h3,
    S_RUN = 4'h4,
    S_BURST = 4'h5,
    S_PROT_CHG = 4'h6,
    S_PROT_WAIT = 4'h7
  } ssbs_state_type;

  typedef struct packed {
    ssbs_state_type st;
    logic hv;
    logic gate;
    logic sleep;
    logic psm;
    logic latched;
    logic fb_prev;
    logic [3:0] init_cnt;
    logic [7:0] steps;
    logic burst_en;
    logic [31:0] win_rl;
    logic [31:0] arm_rl;
    logic [7:0] step_rl;
    logic [5:0] ists;
    logic [5:0] imask;
    logic [31:0] rdata;
    logic err;
  } ssbs_main_type;
endpackage

// ===== core/ssbs_sync.sv
// three-stage synchroniser with agreement filter for comparator inputs
`timescale 1ns/1ps
module ssbs_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic [W-1:0] din, // asynchronous level
  output logic [W-1:0] dout // filtered level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } ssbs_sync_type;
  ssbs_sync_type r_q, r_d;

  // stage shift, output follows once stages two and three agree
  always_comb begin
    r_d = r_q;
    r_d.s1 = din;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.o[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign dout = r_q.o;
endmodule

// ===== core/ssbs_timer.sv
// reloadable down counter giving one done pulse per start
`timescale 1ns/1ps
module ssbs_timer #(
  parameter int TW = 32
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic start, // load and run
  input wire logic [TW-1:0] reload, // cycles to count
  output logic done // one-cycle pulse at expiry
);
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic busy;
    logic done;
  } ssbs_timer_type;
  ssbs_timer_type r_q, r_d;

  // load on start, count down, pulse when it reaches one
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    if (start) begin
      r_d.cnt = (reload == '0) ? TW'(1) : reload;
      r_d.busy = 1'b1;
    end else if (r_q.busy) begin
      if (r_q.cnt == TW'(1)) begin
        r_d.busy = 1'b0;
        r_d.done = 1'b1;
      end
      r_d.cnt = r_q.cnt - TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign done = r_q.done;
endmodule

// ===== core/ssbs_sequencer.sv
// supply start-up and bang-bang sequencer with apb registers
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ssbs_consts.svh"

module ssbs_sequencer
  import ssbs_pkg::*;
#(
  parameter int WIN_CYC = `SSBS_WIN_CYC,
  parameter int ARM_CYC = `SSBS_ARM_CYC
) (
  input wire logic pclk, // clock, 125 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic vcc_below_off, // supply below deactivation threshold
  input wire logic vcc_above_on, // supply above turn-on threshold
  input wire logic vcc_below_wakeup, // supply below sleep wake-up threshold
  input wire logic vs_brownin, // input sense brown-in reached
  input wire logic vs_brownout_fast, // fast brown-out detected
  input wire logic vs_brownout_slow, // slow brown-out detected
  input wire logic fb_above_ctrl, // feedback above burst control threshold
  input wire logic prot_latch_req, // latched protection request
  input wire logic prot_arm_req, // auto-restart protection request
  input wire logic burst_req, // burst operation request
  output logic hv_source_en, // start-up current source on
  output logic gate_enable, // half-bridge drive allowed
  output logic sleep_mode, // low-consumption sleep
  output logic burst_psm, // burst power-saving state
  output logic init_busy, // hardware initialisation running
  output logic irq // level interrupt
);
  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  logic [6:0] cmp_raw;
  logic [6:0] cmp;
  logic below_off, above_on, below_wk, brownin, brownout, fb_hi;

  assign cmp_raw = {fb_above_ctrl, vs_brownout_slow, vs_brownout_fast, vs_brownin,
                    vcc_below_wakeup, vcc_above_on, vcc_below_off};

  // all comparator levels cross into pclk here
  ssbs_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(cmp_raw),
    .dout(cmp)
  );

  assign below_off = cmp[0];
  assign above_on = cmp[1];
  assign below_wk = cmp[2];
  assign brownin = cmp[3];
  assign brownout = cmp[4] | cmp[5];
  assign fb_hi = cmp[6];

  // ----------------------------------------------------------------
  // window and base-period timers
  // ----------------------------------------------------------------
  ssbs_main_type r_q, r_d;
  logic win_start, arm_start, win_done, arm_done;

  ssbs_timer #(.TW(32)) u_win (
    .pclk(pclk),
    .presetn(presetn),
    .start(win_start),
    .reload(r_q.win_rl),
    .done(win_done)
  );

  ssbs_timer #(.TW(32)) u_arm (
    .pclk(pclk),
    .presetn(presetn),
    .start(arm_start),
    .reload(r_q.arm_rl),
    .done(arm_done)
  );

  // ----------------------------------------------------------------
  // sequencer, registers and interrupts
  // ----------------------------------------------------------------
  logic [5:0] ev;
  logic [5:0] w1c;
  logic wr, setup, fb_rise, prot_any;
  logic [7:0] steps_inc;

  // bus phase decode and helpers
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign fb_rise = fb_hi & ~r_q.fb_prev;
  assign prot_any = prot_latch_req | prot_arm_req;
  assign steps_inc = r_q.steps + 8'h01;

  // next-state, register and event logic
  always_comb begin
    r_d = r_q;
    ev = '0;
    w1c = '0;
    win_start = 1'b0;
    arm_start = 1'b0;
    r_d.fb_prev = fb_hi;
    case (r_q.st)
      // power-up charge until turn-on threshold
      S_CHARGE: begin
        r_d.hv = 1'b1;
        if (above_on) begin
          r_d.hv = 1'b0;
          r_d.st = S_INIT;
          r_d.init_cnt = `SSBS_INIT_CYC;
        end
      end

      // fixed hardware initialisation count
      S_INIT: begin
        if (r_q.init_cnt == 4'h0) begin
          r_d.st = S_BI_ACTIVE;
          win_start = 1'b1;
        end else begin
          r_d.init_cnt = r_q.init_cnt - 4'h1;
        end
      end

      // brown-in detection window, awake
      S_BI_ACTIVE: begin
        if (brownin) begin
          r_d.st = S_RUN;
          ev[`SSBS_EV_BROWNIN] = 1'b1;
        end else if (win_done) begin
          r_d.st = S_BI_SLEEP;
          r_d.hv = 1'b1;
        end
      end

      // low-consumption sleep while recharging
      S_BI_SLEEP: begin
        r_d.hv = 1'b1;
        if (above_on) begin
          r_d.hv = 1'b0;
          r_d.st = S_BI_ACTIVE;
          win_start = 1'b1;
        end
      end

      // switching, with burst power saving
      S_RUN, S_BURST: begin
        if (prot_any) begin
          r_d.st = S_PROT_CHG;
          r_d.hv = 1'b1;
          r_d.latched = prot_latch_req;
          r_d.steps = 8'h00;
          ev[`SSBS_EV_PROTECT] = 1'b1;
        end else if (brownout) begin
          r_d.st = S_BI_SLEEP;
          r_d.hv = 1'b1;
          ev[`SSBS_EV_BROWNOUT] = 1'b1;
        end else if (r_q.st == S_RUN) begin
          if (burst_req && r_q.burst_en) begin
            r_d.st = S_BURST;
            r_d.hv = 1'b1;
            ev[`SSBS_EV_BURST] = 1'b1;
          end
        end else if (!burst_req || !r_q.burst_en) begin
          r_d.st = S_RUN;
          r_d.hv = 1'b0;
        end else if (fb_rise || above_on) begin
          r_d.hv = 1'b0;
        // wake-up threshold only armed while power saving, keeps wake-off
        end else if (below_wk && !fb_hi) begin
          r_d.hv = 1'b1;
        end
      end

      // protection bang-bang, charging phase
      S_PROT_CHG: begin
        r_d.hv = 1'b1;
        if (above_on) begin
          r_d.hv = 1'b0;
          r_d.st = S_PROT_WAIT;
          arm_start = 1'b1;
          if (!r_q.latched) begin
            r_d.steps = steps_inc;
            if (steps_inc >= r_q.step_rl) begin
              r_d.st = S_INIT;
              r_d.init_cnt = `SSBS_INIT_CYC;
              r_d.steps = 8'h00;
              arm_start = 1'b0;
              ev[`SSBS_EV_RESTART] = 1'b1;
            end
          end
        end
      end

      // protection bang-bang, base period off
      S_PROT_WAIT: begin
        if (arm_done) begin
          r_d.st = S_PROT_CHG;
          r_d.hv = 1'b1;
        end
      end

      // unused codes fall back to charging
      default: begin
        r_d.st = S_CHARGE;
        r_d.hv = 1'b1;
      end
    endcase

    // supply collapse is the hardware reset, only way out of latch
    if (below_off) begin
      r_d.st = S_CHARGE;
      r_d.hv = 1'b1;
      r_d.latched = 1'b0;
      r_d.steps = 8'h00;
      ev[`SSBS_EV_HWRESET] = (r_q.st != S_CHARGE);
    end

    // registered outputs decoded from the next state
    r_d.gate = (r_d.st == S_RUN) || ((r_d.st == S_BURST) && fb_hi);
    r_d.psm = (r_d.st == S_BURST) && !fb_hi;
    r_d.sleep = (r_d.st == S_BI_SLEEP) || (r_d.st == S_PROT_CHG) ||
                (r_d.st == S_PROT_WAIT);

    // apb writes take effect in the access phase
    if (wr) begin
      case (paddr)
        `SSBS_OFS_CTRL: r_d.burst_en = pwdata[`SSBS_CTRL_BURST_EN];
        `SSBS_OFS_WIN_RELOAD: r_d.win_rl = pwdata;
        `SSBS_OFS_ARM_RELOAD: r_d.arm_rl = pwdata;
        `SSBS_OFS_STEP_COUNT: r_d.step_rl = pwdata[7:0];
        `SSBS_OFS_INT_STATUS: w1c = pwdata[5:0];
        `SSBS_OFS_INT_MASK: r_d.imask = pwdata[5:0];
        default: r_d.err = r_q.err;
      endcase
    end

    // sticky events, a set in the clearing cycle wins
    r_d.ists = (r_q.ists & ~w1c) | ev;

    // read data and error captured in the setup phase
    if (setup) begin
      r_d.err = 1'b0;
      case (paddr)
        `SSBS_OFS_CTRL: r_d.rdata = {31'h0, r_q.burst_en};
        `SSBS_OFS_STATUS: r_d.rdata = {16'h0, r_q.steps, 2'h0, r_q.latched, r_q.hv, r_q.st};
        `SSBS_OFS_WIN_RELOAD: r_d.rdata = r_q.win_rl;
        `SSBS_OFS_ARM_RELOAD: r_d.rdata = r_q.arm_rl;
        `SSBS_OFS_STEP_COUNT: r_d.rdata = {24'h0, r_q.step_rl};
        `SSBS_OFS_INT_STATUS: r_d.rdata = {26'h0, r_q.ists};
        `SSBS_OFS_INT_MASK: r_d.rdata = {26'h0, r_q.imask};
        default: begin
          r_d.rdata = 32'h0;
          r_d.err = 1'b1;
        end
      endcase
    end
  end

  // state register, power-up starts charging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.st <= S_CHARGE;
      r_q.hv <= 1'b1;
      r_q.burst_en <= `SSBS_CTRL_RST;
      r_q.win_rl <= 32'(WIN_CYC);
      r_q.arm_rl <= 32'(ARM_CYC);
      r_q.step_rl <= `SSBS_STEP_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = r_q.rdata;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel & penable & r_q.err;
  assign hv_source_en = r_q.hv;
  assign gate_enable = r_q.gate;
  assign sleep_mode = r_q.sleep;
  assign burst_psm = r_q.psm;
  assign init_busy = (r_q.st == S_INIT);
  assign irq = |(r_q.ists & r_q.imask);
endmodule

// ===== dv/ssbs_sequencer_assertions.sv
// port-level assertions of the supply sequencer
`timescale 1ns/1ps
module ssbs_sequencer_assertions (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic vcc_below_off, // supply low
  input wire logic burst_req, // burst request
  input wire logic fb_above_ctrl, // feedback high
  input wire logic prot_latch_req, // latch request
  input wire logic prot_arm_req, // restart request
  input wire logic hv_source_en, // source on
  input wire logic gate_enable, // drive allowed
  input wire logic sleep_mode, // sleep
  input wire logic burst_psm, // power saving
  input wire logic init_busy // init running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_init_start;
    $rose(init_busy);
  endsequence
  sequence s_init_hold;
    init_busy [*8];
  endsequence
  property p_low_on;
    vcc_below_off [*6] |-> hv_source_en;
  endproperty
  property p_init_len;
    s_init_start |-> s_init_hold;
  endproperty
  property p_init_off;
    init_busy |-> !hv_source_en;
  endproperty
  property p_init_gate;
    init_busy |-> !gate_enable;
  endproperty
  property p_gate_awake;
    gate_enable |-> !sleep_mode && !burst_psm;
  endproperty
  property p_sleep_hv;
    $rose(sleep_mode) && !prot_latch_req && !prot_arm_req |-> hv_source_en;
  endproperty
  property p_wake_off;
    $fell(burst_psm) && burst_req && fb_above_ctrl |-> ##[0:2] !hv_source_en;
  endproperty
  property p_unmapped;
    psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  property p_mapped;
    psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr && pready;
  endproperty
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_low_on: assert property (p_low_on) else $error("source off while supply low");
  a_init_len: assert property (p_init_len) else $error("init too short");
  a_init_off: assert property (p_init_off) else $error("source on in init");
  a_init_gate: assert property (p_init_gate) else $error("gate on in init");
  a_gate_awake: assert property (p_gate_awake) else $error("gate on while asleep");
  a_sleep_hv: assert property (p_sleep_hv) else $error("sleep without charge");
  a_wake_off: assert property (p_wake_off) else $error("source on after wake");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
  a_mapped: assert property (p_mapped) else $error("error on mapped");
endmodule

// ===== dv/ssbs_supply_model.sv
// supply capacitor model driving the supply comparators
`timescale 1ns/1ps
module ssbs_supply_model (
  input wire logic pclk, // clock
  input wire logic hv_source_en, // charge current on
  input wire logic drop, // load pulls supply to zero
  output logic vcc_below_off, // below deactivation
  output logic vcc_above_on, // above turn-on
  output logic vcc_below_wakeup // below wake-up
);
  int vcc = 0;
  int tick = 0;
  // charge one step a cycle, discharge at half rate, self-supply floor
  always @(posedge pclk) begin
    tick <= tick + 1;
    if (drop)
      vcc <= 0;
    else if (hv_source_en && vcc < 100)
      vcc <= vcc + 1;
    else if (!hv_source_en && tick % 2 == 0 && vcc > 20)
      vcc <= vcc - 1;
  end
  assign vcc_below_off = vcc < 10;
  assign vcc_above_on = vcc >= 90;
  assign vcc_below_wakeup = vcc < 60;
endmodule

// ===== dv/ssbs_sequencer_tb_top.sv
// self-checking bench of the supply sequencer
`timescale 1ns/1ps
`include "ssbs_consts.svh"
module ssbs_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drop = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, last_err;
  logic vcc_below_off, vcc_above_on, vcc_below_wakeup;
  logic vs_brownin = 0, vs_brownout_fast = 0, vs_brownout_slow = 0, fb_above_ctrl = 0;
  logic prot_latch_req = 0, prot_arm_req = 0, burst_req = 0;
  logic hv_source_en, gate_enable, sleep_mode, burst_psm, init_busy, irq;
  int n_errors = 0, compares = 0;
  wire logic [4:0] outs = {hv_source_en, burst_psm, sleep_mode, gate_enable, init_busy};
  always #4 pclk = ~pclk;
  ssbs_sequencer #(.WIN_CYC(20), .ARM_CYC(40)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vcc_below_off, .vcc_above_on,
    .vcc_below_wakeup, .vs_brownin, .vs_brownout_fast, .vs_brownout_slow, .fb_above_ctrl,
    .prot_latch_req, .prot_arm_req, .burst_req, .hv_source_en, .gate_enable, .sleep_mode,
    .burst_psm, .init_busy, .irq);
  ssbs_supply_model u_sup (.pclk, .hv_source_en, .drop, .vcc_below_off, .vcc_above_on,
    .vcc_below_wakeup);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, then settle to the falling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 50) begin
      chk(1, 0);
      test_done();
    end
    @(negedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(r, e);
  endtask
  // wait on one output, bounded
  task automatic wait_sig(input int k, input logic v);
    int n;
    n = 0;
    while (outs[k] !== v && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    if (n == 3000) begin
      chk(k, 99);
      test_done();
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence: 0 init, 1 gate, 2 sleep, 3 psm, 4 hv
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(hv_source_en, 1);
    rd(`SSBS_OFS_CTRL, 1);
    rd(`SSBS_OFS_WIN_RELOAD, 20);
    rd(`SSBS_OFS_ARM_RELOAD, 40);
    rd(`SSBS_OFS_STEP_COUNT, 8);
    rd(`SSBS_OFS_INT_MASK, 0);
    rd(8'h40, 0);
    chk(last_err, 1);
    wait_sig(0, 1);
    chk(hv_source_en, 0);
    wait_sig(0, 0);
    chk(gate_enable, 0);
    wait_sig(2, 1);
    chk(hv_source_en, 1);
    @(posedge pclk) vs_brownin <= 1;
    repeat (4) @(negedge pclk);
    chk({sleep_mode, gate_enable}, 2'b10);
    wait_sig(1, 1);
    apb(0, `SSBS_OFS_INT_STATUS, 0);
    chk(r[0], 1);
    chk(irq, 0);
    apb(1, `SSBS_OFS_INT_MASK, 32'h1);
    chk(irq, 1);
    apb(1, `SSBS_OFS_INT_STATUS, 32'h3f);
    chk(irq, 0);
    for (int i = 1; i < 3; i++) begin
      @(posedge pclk) {vs_brownout_slow, vs_brownout_fast} <= 2'(i);
      wait_sig(2, 1);
      chk({gate_enable, hv_source_en}, 2'b01);
      @(posedge pclk) {vs_brownout_slow, vs_brownout_fast} <= 2'b00;
      wait_sig(1, 1);
      chk(sleep_mode, 0);
    end
    apb(1, `SSBS_OFS_CTRL, 32'h0);
    @(posedge pclk) burst_req <= 1;
    repeat (6) @(negedge pclk);
    chk({burst_psm, gate_enable}, 2'b01);
    apb(1, `SSBS_OFS_CTRL, 32'h1);
    @(posedge pclk) burst_req <= 1;
    wait_sig(3, 1);
    chk(hv_source_en, 1);
    wait_sig(4, 0);
    wait_sig(4, 1);
    chk(burst_psm, 1);
    @(posedge pclk) fb_above_ctrl <= 1;
    wait_sig(3, 0);
    repeat (3) @(negedge pclk);
    chk({gate_enable, hv_source_en}, 2'b10);
    @(posedge pclk) burst_req <= 0;
    apb(1, `SSBS_OFS_STEP_COUNT, 2);
    @(posedge pclk) prot_arm_req <= 1;
    wait_sig(2, 1);
    @(posedge pclk) prot_arm_req <= 0;
    wait_sig(4, 0);
    repeat (30) @(negedge pclk);
    chk(hv_source_en, 0);
    rd(`SSBS_OFS_STATUS, 32'h107);
    wait_sig(4, 1);
    wait_sig(0, 1);
    wait_sig(1, 1);
    @(posedge pclk) prot_latch_req <= 1;
    wait_sig(2, 1);
    @(posedge pclk) prot_latch_req <= 0;
    repeat (300) @(negedge pclk);
    chk(sleep_mode, 1);
    @(posedge pclk) drop <= 1;
    @(posedge pclk) drop <= 0;
    wait_sig(2, 0);
    rd(`SSBS_OFS_STATUS, 32'h10);
    rd(`SSBS_OFS_INT_STATUS, 32'h3f);
    test_done();
  end
endmodule
bind ssbs_sequencer ssbs_sequencer_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .vcc_below_off, .burst_req, .fb_above_ctrl, .prot_latch_req,
  .prot_arm_req, .hv_source_en, .gate_enable, .sleep_mode, .burst_psm, .init_busy);
